// >>> src/ocap_regbank.sv
// Purpose: APB register bank for output sync, zero-delay routing, channel start-up timers
//          and first analog PLL control with its calibration sequencer
// Assumes: APB slave, always ready; one aligned word per register at four times its index
// Notes:   one packed state struct, filled combinationally and registered once
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps

module ocap_regbank
  import ocap_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // channel supplies and status
  input  wire logic [5:0]          output_supply_valid,
  output logic      [5:0]          channel_active,
  output logic      [5:0]          channel_sync_enable,
  output logic      [7:0]          sync_bank_enable,
  // zero-delay and bypass routing
  output logic      [2:0]          upper_zero_delay_route,
  output logic      [2:0]          lower_zero_delay_route,
  output ocap_byp_t                bypass_source,
  // first analog pll
  output ocap_apll_ctl_t           apll_a_ctl,
  output ocap_cal_stat_t           apll_a_cal,
  // second analog pll
  output logic                     apll_b_power_down,
  output logic                     apll_b_ref_doubler
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]            sync_bank;
    logic [5:0]            sync_en;
    logic [2:0]            zdm_up;
    logic [2:0]            zdm_lo;
    logic [5:0][2:0]       dly_code;
    logic [1:0]            bypass;
    logic                  a_pdn;
    logic                  a_dbl;
    logic                  cp_rsvd;
    logic [1:0]            cp;
    logic [3:0]            pdiv1;
    logic [3:0]            pdiv2;
    logic [3:0]            rsvd93;
    logic [5:0]            bleed;
    logic [1:0]            clsw;
    logic [1:0]            vcow;
    logic                  b_pdn;
    logic                  b_dbl;
    logic [31:0]           rdata;
    logic [TICK_W-1:0]     tick_cnt;
    logic                  tick;
    logic [5:0][CNT_W-1:0] dly_cnt;
    logic [5:0]            active;
    ocap_cal_t             cal;
    logic [CNT_W-1:0]      cal_cnt;
    logic [2:0]            step;
    logic [3:0]            pdiv1_eff;
    logic [3:0]            pdiv2_eff;
  } ocap_state_t;

  localparam ocap_state_t ST_RST = '{
    sync_bank: RST_SYNC_BANK, sync_en: RST_SYNC_EN, zdm_up: RST_ZDM, zdm_lo: RST_ZDM,
    dly_code: {6{RST_DLY_CODE}}, bypass: RST_BYPASS, a_pdn: RST_PDN, a_dbl: RST_DBL,
    cp_rsvd: 1'b0, cp: RST_CP, pdiv1: RST_PDIV, pdiv2: RST_PDIV, rsvd93: RST_RSVD93,
    bleed: RST_BLEED, clsw: RST_CALW, vcow: RST_CALW, b_pdn: RST_PDN, b_dbl: RST_DBL,
    rdata: 32'h0000_0000, tick_cnt: '0, tick: 1'b0, dly_cnt: '0, active: 6'h00,
    cal: CAL_OFF, cal_cnt: '0, step: 3'h0, pdiv1_eff: RST_PDIV, pdiv2_eff: RST_PDIV
  };

  ocap_state_t st_ff;
  ocap_state_t nxt_st;

  // ----------------------------------------------------------------
  // code tables
  // ----------------------------------------------------------------
  function automatic logic [CNT_W-1:0] dly_ticks(input logic [2:0] code);
    int us;
    us = DLY_US_0;
    case (code)
      3'h0: us = DLY_US_0;
      3'h1: us = DLY_US_1;
      3'h2: us = DLY_US_2;
      3'h3: us = DLY_US_3;
      3'h4: us = DLY_US_4;
      3'h5: us = DLY_US_5;
      3'h6: us = DLY_US_6;
      default: us = DLY_US_7;
    endcase
    return CNT_W'(us / TICK_US);
  endfunction

  function automatic logic [CNT_W-1:0] vco_ticks(input logic [1:0] code);
    int us;
    us = VCOW_US_0;
    case (code)
      2'h0: us = VCOW_US_0;
      2'h1: us = VCOW_US_1;
      2'h2: us = VCOW_US_2;
      default: us = VCOW_US_3;
    endcase
    return CNT_W'(us / TICK_US);
  endfunction

  function automatic logic [CNT_W-1:0] cls_ticks(input logic [1:0] code);
    int us;
    us = CLSW_US_0;
    case (code)
      2'h0: us = CLSW_US_0;
      2'h1: us = CLSW_US_1;
      2'h2: us = CLSW_US_2;
      default: us = CLSW_US_3;
    endcase
    return CNT_W'(us / TICK_US);
  endfunction

  // divide ratio; unlisted codes fall back to the smallest ratio
  function automatic logic [3:0] pdiv_ratio(input logic [3:0] code);
    logic [3:0] r;
    r = 4'h4;
    case (code)
      4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8: r = 4'(code + 4'h1);
      4'hA: r = 4'hB;
      4'hC: r = 4'hD;
      default: r = 4'h4;
    endcase
    return r;
  endfunction

  // one-hot feedback pick; codes other than the listed ones mean off
  function automatic logic [2:0] zdm_decode(input logic [2:0] code);
    logic [2:0] r;
    r = 3'h0;
    case (code)
      3'h1, 3'h2, 3'h4: r = code;
      default: r = 3'h0;
    endcase
    return r;
  endfunction

  function automatic logic idx_mapped(input logic [7:0] idx);
    return (idx >= IDX_SYNC_BANK && idx <= IDX_B_PWR) || idx == IDX_CAL_STAT;
  endfunction

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic [7:0] acc_idx;
  logic       acc_ok;
  logic       wr_go;
  logic [7:0] wd;

  assign acc_idx = paddr[9:2];
  assign acc_ok  = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) && idx_mapped(acc_idx);
  assign wr_go   = psel && penable && pwrite && acc_ok;
  assign wd      = pwdata[7:0];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] rd;
    nxt_st = st_ff;
    rd     = 8'h00;

    // register writes; read-only and reserved-read bits are dropped
    if (wr_go) begin
      case (acc_idx)
        IDX_SYNC_BANK: nxt_st.sync_bank = wd;
        IDX_SYNC_EN:   nxt_st.sync_en = wd[5:0];
        IDX_ZDM_ROUTE: begin
          nxt_st.zdm_up = wd[ZDM_UP_LSB+:3];
          nxt_st.zdm_lo = wd[2:0];
        end
        IDX_DLY_CH01: begin
          nxt_st.dly_code[0] = wd[2:0];
          nxt_st.dly_code[1] = wd[DLY_HI_LSB+:3];
        end
        IDX_DLY_CH2345: begin
          nxt_st.dly_code[2] = wd[2:0];
          nxt_st.dly_code[3] = wd[DLY_HI_LSB+:3];
        end
        IDX_DLY_CH67: begin
          nxt_st.dly_code[4] = wd[2:0];
          nxt_st.dly_code[5] = wd[DLY_HI_LSB+:3];
        end
        IDX_BYPASS:    nxt_st.bypass = wd[1:0];
        IDX_A_PWR: begin
          nxt_st.a_pdn = wd[PDN_BIT];
          nxt_st.a_dbl = wd[DBL_BIT];
        end
        IDX_A_PUMP: begin
          nxt_st.cp_rsvd = wd[CP_RSVD_BIT];
          nxt_st.cp      = wd[1:0];
        end
        IDX_A_PDIV: begin
          nxt_st.pdiv1 = wd[3:0];
          nxt_st.pdiv2 = wd[PDIV2_LSB+:4];
        end
        IDX_A_RSVD:    nxt_st.rsvd93 = wd[3:0];
        IDX_A_BLEED:   nxt_st.bleed = wd[5:0];
        IDX_A_CALWAIT: begin
          nxt_st.vcow = wd[1:0];
          nxt_st.clsw = wd[CALW_CL_LSB+:2];
        end
        IDX_B_PWR: begin
          nxt_st.b_pdn = wd[PDN_BIT];
          nxt_st.b_dbl = wd[DBL_BIT];
        end
        default: ;
      endcase
    end

    // read data is latched in the setup phase so prdata comes from a flop
    case (acc_idx)
      IDX_SYNC_BANK:  rd = st_ff.sync_bank;
      IDX_SYNC_EN:    rd = {2'h0, st_ff.sync_en};
      IDX_ZDM_ROUTE:  rd = {2'h0, st_ff.zdm_up, st_ff.zdm_lo};
      IDX_DLY_CH01:   rd = {2'h0, st_ff.dly_code[1], st_ff.dly_code[0]};
      IDX_DLY_CH2345: rd = {2'h0, st_ff.dly_code[3], st_ff.dly_code[2]};
      IDX_DLY_CH67:   rd = {2'h0, st_ff.dly_code[5], st_ff.dly_code[4]};
      IDX_ACT_STAT:   rd = {2'h0, st_ff.active};
      IDX_BYPASS:     rd = {6'h00, st_ff.bypass};
      IDX_A_PWR:      rd = {6'h00, st_ff.a_dbl, st_ff.a_pdn};
      IDX_A_PUMP:     rd = {5'h00, st_ff.cp_rsvd, st_ff.cp};
      IDX_A_PDIV:     rd = {st_ff.pdiv2, st_ff.pdiv1};
      IDX_A_RSVD:     rd = {4'h0, st_ff.rsvd93};
      IDX_A_BLEED:    rd = {2'h0, st_ff.bleed};
      IDX_A_CALWAIT:  rd = {4'h0, st_ff.clsw, st_ff.vcow};
      IDX_B_PWR:      rd = {6'h00, st_ff.b_dbl, st_ff.b_pdn};
      IDX_CAL_STAT:   rd = {1'b0, st_ff.step, st_ff.cal};
      default:        rd = 8'h00;
    endcase
    if (psel && !penable) begin
      nxt_st.rdata = acc_ok ? {24'h000000, rd} : 32'h0000_0000;
    end

    // 10 us time base shared by every timer
    nxt_st.tick = 1'b0;
    if (st_ff.tick_cnt >= TICK_W'(TICK_CYCLES - 1)) begin
      nxt_st.tick_cnt = '0;
      nxt_st.tick     = 1'b1;
    end else begin
      nxt_st.tick_cnt = TICK_W'(st_ff.tick_cnt + 1'b1);
    end

    // channel start-up timers
    for (int i = 0; i < 6; i++) begin
      if (!output_supply_valid[i]) begin
        nxt_st.dly_cnt[i] = '0;
        nxt_st.active[i]  = 1'b0;
      end else if (!st_ff.active[i]) begin
        if (st_ff.dly_cnt[i] >= dly_ticks(st_ff.dly_code[i])) begin
          nxt_st.active[i] = 1'b1;
        end else if (st_ff.tick) begin
          nxt_st.dly_cnt[i] = CNT_W'(st_ff.dly_cnt[i] + 1'b1);
        end
      end
    end

    // calibration sequencer
    if (st_ff.a_pdn) begin
      nxt_st.cal     = CAL_OFF;
      nxt_st.cal_cnt = '0;
      nxt_st.step    = 3'h0;
    end else begin
      case (st_ff.cal)
        CAL_OFF: begin
          // leaving power-down behaves as a pll reset: new dividers take hold here
          nxt_st.cal       = CAL_VCO;
          nxt_st.cal_cnt   = '0;
          nxt_st.step      = 3'h0;
          nxt_st.pdiv1_eff = pdiv_ratio(st_ff.pdiv1);
          nxt_st.pdiv2_eff = pdiv_ratio(st_ff.pdiv2);
        end
        CAL_VCO: begin
          if (st_ff.tick) begin
            if (CNT_W'(st_ff.cal_cnt + 1'b1) >= vco_ticks(st_ff.vcow)) begin
              nxt_st.cal     = CAL_STEP;
              nxt_st.cal_cnt = '0;
            end else begin
              nxt_st.cal_cnt = CNT_W'(st_ff.cal_cnt + 1'b1);
            end
          end
        end
        CAL_STEP: begin
          if (st_ff.tick) begin
            if (CNT_W'(st_ff.cal_cnt + 1'b1) >= cls_ticks(st_ff.clsw)) begin
              nxt_st.cal_cnt = '0;
              if (st_ff.step == 3'(CAL_STEPS - 1)) begin
                nxt_st.cal = CAL_DONE;
              end else begin
                nxt_st.step = 3'(st_ff.step + 1'b1);
              end
            end else begin
              nxt_st.cal_cnt = CNT_W'(st_ff.cal_cnt + 1'b1);
            end
          end
        end
        CAL_DONE: nxt_st.cal = CAL_DONE;
        default:  nxt_st.cal = CAL_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata  = st_ff.rdata;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !acc_ok;

  assign channel_active      = st_ff.active;
  assign channel_sync_enable = st_ff.sync_en;
  assign sync_bank_enable    = st_ff.sync_bank;

  assign upper_zero_delay_route = zdm_decode(st_ff.zdm_up);
  assign lower_zero_delay_route = zdm_decode(st_ff.zdm_lo);

  // a clear upper bit picks the crystal whatever the lower bit holds
  assign bypass_source = !st_ff.bypass[1] ? BYP_XO :
                         (st_ff.bypass[0] ? BYP_DPLL1 : BYP_DPLL2);

  assign apll_a_ctl.enable       = !st_ff.a_pdn;
  assign apll_a_ctl.ref_doubler  = st_ff.a_dbl;
  assign apll_a_ctl.pump_gain    = st_ff.cp;
  assign apll_a_ctl.bleed_select = st_ff.bleed;
  assign apll_a_ctl.post_div_one = st_ff.pdiv1_eff;
  assign apll_a_ctl.post_div_two = st_ff.pdiv2_eff;

  assign apll_a_cal.state = st_ff.cal;
  assign apll_a_cal.step  = st_ff.step;
  assign apll_a_cal.done  = (st_ff.cal == CAL_DONE);

  assign apll_b_power_down  = st_ff.b_pdn;
  assign apll_b_ref_doubler = st_ff.b_dbl;

endmodule

// >>> inc/ocap_pkg.sv
// Purpose: constants and types for the output channel and first analog PLL register bank
// Assumes: 100 MHz pclk, APB with 32-bit data, one aligned word per register
// Notes:   printed offsets are register indices; byte address is four times the index
package ocap_pkg;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_SYNC_BANK    = 8'h52;
  localparam logic [7:0] IDX_SYNC_EN      = 8'h53;
  localparam logic [7:0] IDX_ZDM_ROUTE    = 8'h54;
  localparam logic [7:0] IDX_DLY_CH01     = 8'h55;
  localparam logic [7:0] IDX_DLY_CH2345   = 8'h56;
  localparam logic [7:0] IDX_DLY_CH67     = 8'h57;
  localparam logic [7:0] IDX_ACT_STAT     = 8'h58;
  localparam logic [7:0] IDX_BYPASS       = 8'h59;
  localparam logic [7:0] IDX_A_PWR        = 8'h5A;
  localparam logic [7:0] IDX_A_PUMP       = 8'h5B;
  localparam logic [7:0] IDX_A_PDIV       = 8'h5C;
  localparam logic [7:0] IDX_A_RSVD       = 8'h5D;
  localparam logic [7:0] IDX_A_BLEED      = 8'h5E;
  localparam logic [7:0] IDX_A_CALWAIT    = 8'h5F;
  localparam logic [7:0] IDX_B_PWR        = 8'h60;
  localparam logic [7:0] IDX_CAL_STAT     = 8'h7F;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ZDM_UP_LSB  = 3;
  localparam int DLY_HI_LSB  = 3;
  localparam int CALW_CL_LSB = 2;
  localparam int PDIV2_LSB   = 4;
  localparam int PDN_BIT     = 0;
  localparam int DBL_BIT     = 1;
  localparam int CP_RSVD_BIT = 2;
  localparam int STAT_STEP_LSB = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_SYNC_BANK = 8'h00;
  localparam logic [5:0] RST_SYNC_EN   = 6'h00;
  localparam logic [2:0] RST_ZDM       = 3'h0;
  localparam logic [2:0] RST_DLY_CODE  = 3'h0;
  localparam logic [1:0] RST_BYPASS    = 2'h0;
  localparam logic       RST_PDN       = 1'b0;
  localparam logic       RST_DBL       = 1'b0;
  localparam logic [1:0] RST_CP        = 2'h0;
  localparam logic [3:0] RST_PDIV      = 4'h3;
  localparam logic [3:0] RST_RSVD93    = 4'h0;
  localparam logic [5:0] RST_BLEED     = 6'h00;
  localparam logic [1:0] RST_CALW      = 2'h0;

  // ----------------------------------------------------------------
  // timing: a 10 us tick drives every timer
  // ----------------------------------------------------------------
  localparam int CLK_NS   = 10;
  localparam int TICK_US  = 10;
  localparam int TICK_CYC = (TICK_US * 1000) / CLK_NS;
  localparam int CNT_W    = 15;
  localparam int TICK_W   = 16;
  localparam int CAL_STEPS = 7;

  // start-up delay per code, in us
  localparam int DLY_US_0 = 0;
  localparam int DLY_US_1 = 500;
  localparam int DLY_US_2 = 1000;
  localparam int DLY_US_3 = 2000;
  localparam int DLY_US_4 = 4000;
  localparam int DLY_US_5 = 8000;
  localparam int DLY_US_6 = 16000;
  localparam int DLY_US_7 = 64000;
  // vco wait per code, in us
  localparam int VCOW_US_0 = 20;
  localparam int VCOW_US_1 = 400;
  localparam int VCOW_US_2 = 8000;
  localparam int VCOW_US_3 = 200000;
  // closed-loop wait per step, in us
  localparam int CLSW_US_0 = 300;
  localparam int CLSW_US_1 = 3000;
  localparam int CLSW_US_2 = 30000;
  localparam int CLSW_US_3 = 300000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CAL_OFF  = 4'h1,
    CAL_VCO  = 4'h2,
    CAL_STEP = 4'h4,
    CAL_DONE = 4'h8
  } ocap_cal_t;

  typedef enum logic [1:0] {
    BYP_XO    = 2'h0,
    BYP_DPLL2 = 2'h1,
    BYP_DPLL1 = 2'h2
  } ocap_byp_t;

  typedef struct packed {
    logic       enable;
    logic       ref_doubler;
    logic [1:0] pump_gain;
    logic [5:0] bleed_select;
    logic [3:0] post_div_one;
    logic [3:0] post_div_two;
  } ocap_apll_ctl_t;

  typedef struct packed {
    ocap_cal_t  state;
    logic [2:0] step;
    logic       done;
  } ocap_cal_stat_t;

endpackage

// >>> sim/ocap_regbank_chk.sv
// Purpose: concurrent checks on the register bank ports
// Assumes: one pclk domain, presetn asynchronous and active low
// Notes:   attached by the bind at the foot of this file
`timescale 1ns/1ps

module ocap_regbank_chk
  import ocap_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  // clock and reset
  input wire logic           pclk,
  input wire logic           presetn,
  // apb
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [11:0]    paddr,
  input wire logic [31:0]    pwdata,
  input wire logic [31:0]    prdata,
  input wire logic           pready,
  input wire logic           pslverr,
  // channels and pll
  input wire logic [5:0]     output_supply_valid,
  input wire logic [5:0]     channel_active,
  input wire logic [5:0]     channel_sync_enable,
  input wire logic [7:0]     sync_bank_enable,
  input wire logic [2:0]     upper_zero_delay_route,
  input wire logic [2:0]     lower_zero_delay_route,
  input wire ocap_apll_ctl_t apll_a_ctl,
  input wire ocap_cal_stat_t apll_a_cal
);
  // --------------------------------
  // decode helpers
  // --------------------------------
  logic [7:0] idx;
  logic       mapped;
  logic       wr_acc;
  ocap_cal_t  st;

  assign idx    = paddr[9:2];
  assign mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
                  (((idx >= IDX_SYNC_BANK) && (idx <= IDX_B_PWR)) || (idx == IDX_CAL_STAT));
  assign wr_acc = psel && penable && pwrite && mapped;
  assign st     = apll_a_cal.state;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // --------------------------------
  // assertions
  // --------------------------------
  a_err_decode: assert property (psel && penable |-> pready && (pslverr == !mapped))
    else $error("error response disagrees with address decode");
  a_act_supply: assert property ((channel_active & ~$past(output_supply_valid)) == 6'h00)
    else $error("channel active while its supply was low");
  a_act_read: assert property (psel && !penable && !pwrite && mapped && idx == IDX_ACT_STAT |=>
    prdata == {26'h0, $past(channel_active)}) else $error("active status read wrong");
  a_sync_write: assert property (wr_acc && idx == IDX_SYNC_EN |=>
    channel_sync_enable == $past(pwdata[5:0])) else $error("sync enables not taken");
  a_bank_write: assert property (wr_acc && idx == IDX_SYNC_BANK |=>
    sync_bank_enable == $past(pwdata[7:0])) else $error("sync bank enables not taken");
  a_zdm_decode: assert property (wr_acc && idx == IDX_ZDM_ROUTE |=>
    (lower_zero_delay_route == ($onehot($past(pwdata[2:0])) ? $past(pwdata[2:0]) : 3'h0)) &&
    (upper_zero_delay_route == ($onehot($past(pwdata[5:3])) ? $past(pwdata[5:3]) : 3'h0)))
    else $error("zero delay route decode wrong");
  a_pdn_stop: assert property (wr_acc && idx == IDX_A_PWR && pwdata[PDN_BIT] |=>
    !apll_a_ctl.enable ##[0:1] st == CAL_OFF) else $error("power down did not stop pll");
  // the edge that releases reset still leaves the sequencer off, so only start from a sampled-live reset
  a_cal_start: assert property (presetn && st == CAL_OFF && apll_a_ctl.enable |=> st == CAL_VCO)
    else $error("calibration did not restart");
  a_done_hold: assert property (st == CAL_DONE && apll_a_ctl.enable |=> st == CAL_DONE)
    else $error("calibration left done state");
  a_step_order: assert property (st == CAL_STEP && $past(st) != CAL_STEP |-> $past(st) == CAL_VCO)
    else $error("steps began without vco wait");
endmodule

bind ocap_regbank ocap_regbank_chk #(.TICK_CYCLES(TICK_CYCLES)) i_ocap_regbank_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .output_supply_valid(output_supply_valid), .channel_active(channel_active),
  .channel_sync_enable(channel_sync_enable), .sync_bank_enable(sync_bank_enable),
  .upper_zero_delay_route(upper_zero_delay_route), .lower_zero_delay_route(lower_zero_delay_route),
  .apll_a_ctl(apll_a_ctl), .apll_a_cal(apll_a_cal)
);

// >>> sim/tb_ocap_regbank.sv
// Purpose: self-checking bench for the output channel and pll register bank
// Assumes: TICK_CYCLES cut to 4 so timers and calibration finish quickly
// Notes:   expectations come from local tables, never from the bank
`timescale 1ns/1ps

module tb_ocap_regbank
  import ocap_pkg::*;
;
  // --------------------------------
  // signals and tables
  // --------------------------------
  localparam int T = 4;
  logic           pclk;
  logic           presetn;
  logic           psel;
  logic           penable;
  logic           pwrite;
  logic           pready;
  logic           pslverr;
  logic [11:0]    paddr;
  logic [31:0]    pwdata;
  logic [31:0]    prdata;
  logic [31:0]    rd;
  logic           er;
  logic [5:0]     sup;
  logic [5:0]     act;
  logic [5:0]     sen;
  logic [7:0]     sbe;
  logic [2:0]     uzr;
  logic [2:0]     lzr;
  ocap_byp_t      byp;
  ocap_apll_ctl_t actl;
  ocap_cal_stat_t acal;
  logic           bpd;
  logic           bdb;
  int             miscompares;
  int             comparisons;
  logic [7:0]     ridx [14] = '{8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h59, 8'h5A, 8'h5B, 8'h5C,
                                8'h5D, 8'h5E, 8'h5F, 8'h60};
  logic [7:0]     rmsk [14] = '{8'hFF, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h03, 8'h03, 8'h07, 8'hFF,
                                8'h0F, 8'h3F, 8'h0F, 8'h03};
  logic [3:0]     dcod [8]  = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hA, 4'hC};
  int             ratio [8] = '{4, 5, 6, 7, 8, 9, 11, 13};
  int             dly [8]   = '{0, 50, 100, 200, 400, 800, 1600, 6400};

  ocap_regbank #(.TICK_CYCLES(T)) i_ocap_regbank (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .output_supply_valid(sup),
    .channel_active(act), .channel_sync_enable(sen), .sync_bank_enable(sbe), .upper_zero_delay_route(uzr),
    .lower_zero_delay_route(lzr), .bypass_source(byp), .apll_a_ctl(actl), .apll_a_cal(acal),
    .apll_b_power_down(bpd), .apll_b_ref_doubler(bdb));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // --------------------------------
  // tasks
  // --------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic tmo(input logic bad);
    if (bad) begin
      miscompares++;
      $display("ERROR wait expected done seen timeout");
      wrap_up();
    end
  endtask

  // always starts one edge after the last release, so no signal is assigned twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    tmo(n >= 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, {2'b00, i, 2'b00}, d);
  endtask

  task automatic rdc(input logic [7:0] i, input logic [7:0] e);
    apb(1'b0, {2'b00, i, 2'b00}, 8'h00);
    chk($sformatf("reg %h", i), {24'h0, e}, rd);
  endtask

  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    int         n;
    logic [5:0] seen;
    logic [2:0] cd [6];
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sup = 6'h00;
    miscompares = 0;
    comparisons = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      rdc(ridx[i], (ridx[i] == 8'h5C) ? 8'h33 : 8'h00);
    end
    rdc(8'h58, 8'h00);
    chk("pll enable", 32'h1, actl.enable);
    for (int i = 0; i < 14; i++) begin
      wr(ridx[i], 8'hFF);
      rdc(ridx[i], rmsk[i]);
    end
    @(negedge pclk);
    chk("bank", 32'hFF, sbe);
    chk("sync", 32'h3F, sen);
    chk("ctl", {1'b0, 1'b1, 2'h3, 6'h3F, 4'h4, 4'h4}, actl);
    chk("pll b", 32'h3, {bdb, bpd});
    chk("cal off", CAL_OFF, acal.state);
    for (int i = 0; i < 14; i++) wr(ridx[i], 8'h00);
    apb(1'b0, 12'h184, 8'h00);
    chk("unmapped err", 32'h1, er);
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, 12'h149, 8'hFF);
    chk("misaligned err", 32'h1, er);
    wr(8'h58, 8'hFF);
    chk("status err", 32'h0, er);
    rdc(8'h58, 8'h00);
    rdc(8'h52, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(8'h54, 8'(c * 9));
      @(negedge pclk);
      chk("upper zdm", $onehot(3'(c)) ? c : 0, uzr);
      chk("lower zdm", $onehot(3'(c)) ? c : 0, lzr);
    end
    for (int c = 0; c < 4; c++) begin
      wr(8'h59, 8'(c));
      @(negedge pclk);
      chk("bypass", (c < 2) ? BYP_XO : ((c == 2) ? BYP_DPLL2 : BYP_DPLL1), byp);
    end
    for (int i = 0; i < 8; i++) begin
      wr(8'h5C, {dcod[(i + 1) % 8], dcod[i]});
      @(negedge pclk);
      chk("div held", (i == 0) ? 4 : ratio[(i + 7) % 8], actl.post_div_one);
      wr(8'h5A, 8'h01);
      wr(8'h5A, 8'h00);
      repeat (3) @(posedge pclk);
      chk("div one", ratio[i], actl.post_div_one);
      chk("div two", ratio[(i + 1) % 8], actl.post_div_two);
    end
    for (int k = 0; k < 2; k++) begin
      wr(8'h5F, k ? 8'h05 : 8'h00);
      wr(8'h5A, 8'h01);
      apb(1'b0, 12'h1FC, 8'h00);
      chk("cal stat off", 32'h1, rd);
      chk("cal done off", 32'h0, acal.done);
      wr(8'h5A, 8'h00);
      for (n = 0; n < 9000 && acal.state !== CAL_DONE; n++) @(posedge pclk);
      tmo(n >= 9000);
      chk("cal time", 1, n >= (k ? 2130 : 205) * T && n <= (k ? 2150 : 220) * T);
      apb(1'b0, 12'h1FC, 8'h00);
      chk("cal stat done", {25'h0, 3'(CAL_STEPS - 1), 4'h8}, rd);
      chk("cal done", 32'h1, acal.done);
      chk("cal step", CAL_STEPS - 1, acal.step);
    end
    for (int p = 0; p < 2; p++) begin
      for (int g = 0; g < 6; g++) cd[g] = 3'(g + 6 * p);
      wr(8'h55, {2'b00, cd[1], cd[0]});
      wr(8'h56, {2'b00, cd[3], cd[2]});
      wr(8'h57, {2'b00, cd[5], cd[4]});
      sup <= 6'h3F;
      seen = 6'h00;
      for (n = 1; n < 27000 && act !== 6'h3F; n++) begin
        @(posedge pclk);
        for (int g = 0; g < 6; g++) begin
          if (act[g] === 1'b1 && !seen[g]) begin
            seen[g] = 1'b1;
            chk("start delay", 1, n >= (dly[cd[g]] - 1) * T && n <= dly[cd[g]] * T + T + 3);
          end
        end
      end
      tmo(act !== 6'h3F);
      rdc(8'h58, 8'h3F);
      sup <= 6'h3B;
      repeat (2) @(negedge pclk);
      chk("supply drop", 32'h3B, act);
      @(posedge pclk);
      sup <= 6'h00;
      repeat (3) @(posedge pclk);
    end
    wrap_up();
  end
endmodule
